// ==== hw/ccc_cfg.svh ====
/*
 Offsets, field positions, write masks, reset values and counts of the
 calendar clock control block. Assumes byte addressing, one word per register.
*/
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH
`define CCC_OFS_CTL1L 8'h00
`define CCC_OFS_CTL1H 8'h04
`define CCC_OFS_CTL2L 8'h08
`define CCC_OFS_CTL2H 8'h0c
`define CCC_OFS_CTL3L 8'h10
`define CCC_OFS_STATL 8'h14
`define CCC_OFS_KEY 8'h18
`define CCC_OFS_SECW 8'h1c
`define CCC_B_UEN 15
`define CCC_B_LOCK 11
`define CCC_B_POWER_CTRL_ENABLE 10
`define CCC_B_POWER_CTRL_POLARITY 9
`define CCC_B_POWER_CTRL_PIN_ENABLE 8
`define CCC_B_OUTEN 7
`define CCC_L_OUTPUT_SELECT 4
`define CCC_B_TSEN 0
`define CCC_B_ALEN 15
`define CCC_B_CHIME 14
`define CCC_L_ALARM_PERIOD_SELECT 8
`define CCC_L_FRACTIONAL_DIVIDE 11
`define CCC_L_POWER_CTRL_PRESCALE 6
`define CCC_L_PS 4
`define CCC_B_ALMEV 5
`define CCC_B_TSEV 3
`define CCC_M_CTL1L 16'h8ff1
`define CCC_M_CTL1H 16'hcfff
`define CCC_M_CTL2L 16'hf8f3
`define CCC_RST_CTL2H 16'h3fff
`define CCC_KEY_FIRST 8'h55
`define CCC_KEY_SECOND 8'haa
`define CCC_PRE_16 8'h0f
`define CCC_PRE_64 8'h3f
`define CCC_PRE_256 8'hff
`define CCC_SAMP_ALWAYS 8'hff
`define CCC_SYNC_MARGIN 16'h0008
`endif

// ==== hw/ccc_pkg.sv ====
/*
 Types of the calendar clock control block.
 Assumes ccc_cfg.svh for all numeric constants.
*/
package ccc_pkg;
   typedef logic [15:0] ccc_reg_t;
   typedef enum logic [1:0] {PWC_IDLE, PWC_STAB, PWC_SAMP} ccc_pwc_e;
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} ccc_key_e;
endpackage : ccc_pkg

// ==== hw/ccc_ctrl.sv ====
/*
 Calendar clock control: write lock with key unlock, source select,
 prescalers, coarse and fractional divider, alarm, power control,
 timestamp and output pin, behind an AHB-Lite slave.
 Assumes a calendar counter on mclk that supplies field equality flags.
*/
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ccc_cfg.svh"
// Behaviour
// - Write lock is zero after every reset.
// - Locked: writes to unit enable, control two and seconds value are dropped.
// - Locked: control one, alarm and timestamp writes still accepted.
// - Clearing the lock needs 0x55 then 0xAA key writes, next write only.
// - Unlocked: lock is set by a plain write.
// - Source select: crystal, RC, powerline pin, system clock.
// - Divider counts only while unit enable is one.
// - Power control enable, polarity and pin enable bits.
// - Output pin source chosen by output select when output enabled.
// - Timestamp event on tamper low pulse when timestamp enabled.
// - Alarm enable clears after event when repeat zero and chime off.
// - Chime on wraps repeat count to FFh, else it stops at zero.
// - Alarm period select decodes half second up to year; reserved codes never fire.
// - Repeat count decrements on every alarm event while it is nonzero.
// - Fractional value N adds N input cycles per 16 seconds.
// - Both prescalers decode 1:1, 1:16, 1:64, 1:256.
// - Coarse divide value sets divider reload period.
// - Sample window N periods, zero none, FFh always on.
// - Stability window precedes sample window; zero starts sample at alarm.
// - Alarm and timestamp event flags, software clearable.
// - Writing one to timestamp flag starts a capture.
// - Sync bits show time and alarm registers about to change.
// - Half-second bit tracks second half, cleared by seconds write.
// - Sixteen-bit down counter reloaded from coarse divide value.
// - Pulse deletion once per half second, up to 31 per 16 s.
module ccc_ctrl #(
   parameter logic [15:0] SYNC_MARGIN = `CCC_SYNC_MARGIN
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic secondary_crystal_osc,
   input wire logic low_power_rc_osc,
   input wire logic powerline_clock_pin,
   input wire logic tamper_input_n,
   input wire logic [7:0] field_match,
   output logic output_pin,
   output logic power_ctrl_out,
   output logic power_ctrl_pin_enable,
   output logic timestamp_capture,
   output logic half_tick_out
);
   import ccc_pkg::*;

   initial begin
      if (SYNC_MARGIN == 16'h0000) begin
         $error("SYNC_MARGIN must be nonzero");
      end
   end

   function automatic logic [7:0] pre_max(input logic [1:0] sel);
      unique case (sel)
         2'b00: pre_max = 8'h00;
         2'b01: pre_max = `CCC_PRE_16;
         2'b10: pre_max = `CCC_PRE_64;
         2'b11: pre_max = `CCC_PRE_256;
      endcase
   endfunction : pre_max

   // Fields: 0 sec ones, 1 sec tens, 2 min ones, 3 min tens, 4 hour, 5 weekday, 6 day, 7 month
   function automatic logic alarm_hit(input logic [3:0] m, input logic [7:0] f, input logic sec);
      logic hms;
      hms = &f[4:0];
      case (m)
         4'h0: alarm_hit = 1'b1;
         4'h1: alarm_hit = sec;
         4'h2: alarm_hit = sec & f[0];
         4'h3: alarm_hit = sec & (&f[1:0]);
         4'h4: alarm_hit = sec & (&f[2:0]);
         4'h5: alarm_hit = sec & (&f[3:0]);
         4'h6: alarm_hit = sec & hms;
         4'h7: alarm_hit = sec & hms & f[5];
         4'h8: alarm_hit = sec & hms & f[6];
         4'h9: alarm_hit = sec & hms & f[6] & f[7];
         default: alarm_hit = 1'b0;
      endcase
   endfunction : alarm_hit

   ccc_reg_t ctl1l_q, ctl1h_q, ctl2l_q, ctl2h_q, ctl3l_q;
   logic [7:0] a_q;
   logic wr_pend_q, rd_pend_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   ccc_key_e key_q;
   logic [3:0] sync1_q, sync2_q, sync3_q;
   logic [7:0] ps_cnt_q, pwps_cnt_q;
   logic [15:0] div_cnt_q;
   logic del_q;
   logic [4:0] hs_idx_q;
   logic half_q;
   logic stat_alm_q, stat_ts_q;
   ccc_pwc_e pwc_q;
   logic [7:0] pwc_cnt_q;
   logic out_pin_q, pwr_q, pwr_en_q, ts_cap_q, half_tick_q;

   logic lock, uen, wr_data_ok;
   logic wr_ctl1l, wr_ctl1h, wr_ctl2l, wr_ctl2h, wr_ctl3l, wr_stat, wr_key, wr_sec;
   logic [3:0] rise, fall;
   logic src_p, pre_p, pwc_p, half_tick, sec_tick, alm_ev, ts_ev, pwc_act;
   logic [7:0] rpt, samp_len, stab_len;
   logic [15:0] rd_val;
   ccc_reg_t ctl1l_d;

   assign lock = ctl1l_q[`CCC_B_LOCK];
   assign uen = ctl1l_q[`CCC_B_UEN];
   assign rpt = ctl1h_q[7:0];
   assign samp_len = ctl3l_q[15:8];
   assign stab_len = ctl3l_q[7:0];
   assign wr_data_ok = wr_pend_q & hready;
   assign wr_ctl1l = wr_data_ok & (a_q == `CCC_OFS_CTL1L);
   assign wr_ctl1h = wr_data_ok & (a_q == `CCC_OFS_CTL1H);
   assign wr_ctl2l = wr_data_ok & (a_q == `CCC_OFS_CTL2L) & ~lock;
   assign wr_ctl2h = wr_data_ok & (a_q == `CCC_OFS_CTL2H) & ~lock;
   assign wr_ctl3l = wr_data_ok & (a_q == `CCC_OFS_CTL3L);
   assign wr_stat = wr_data_ok & (a_q == `CCC_OFS_STATL);
   assign wr_key = wr_data_ok & (a_q == `CCC_OFS_KEY);
   assign wr_sec = wr_data_ok & (a_q == `CCC_OFS_SECW) & ~lock;

   // Bus slave: writes take no wait state, reads take one so a read right after
   // a write always sees the written value.
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         a_q <= 8'h00;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= hsel & htrans[1] & hready & hwrite;
         rd_pend_q <= hsel & htrans[1] & hready & ~hwrite;
         hreadyout_q <= ~(hsel & htrans[1] & hready & ~hwrite);
         if (hsel & htrans[1] & hready) begin
            a_q <= haddr[7:0];
         end
         if (rd_pend_q) begin
            hrdata_q <= {16'h0000, rd_val};
         end
      end
   end

   always_comb begin
      unique case (a_q)
         `CCC_OFS_CTL1L: rd_val = ctl1l_q;
         `CCC_OFS_CTL1H: rd_val = ctl1h_q;
         `CCC_OFS_CTL2L: rd_val = ctl2l_q;
         `CCC_OFS_CTL2H: rd_val = ctl2h_q;
         `CCC_OFS_CTL3L: rd_val = ctl3l_q;
         `CCC_OFS_STATL: rd_val = {10'h000, stat_alm_q, 1'b0, stat_ts_q,
            uen & (div_cnt_q < SYNC_MARGIN), uen & (div_cnt_q < SYNC_MARGIN), half_q};
         default: rd_val = 16'h0000;
      endcase
   end

   // Key sequence: any write other than the expected one starts over
   always_ff @(posedge mclk) begin
      if (rst) begin
         key_q <= KEY_IDLE;
      end else if (wr_data_ok) begin
         if (wr_key & (hwdata[7:0] == `CCC_KEY_FIRST)) begin
            key_q <= KEY_HALF;
         end else if (wr_key & (key_q == KEY_HALF) & (hwdata[7:0] == `CCC_KEY_SECOND)) begin
            key_q <= KEY_OPEN;
         end else begin
            key_q <= KEY_IDLE;
         end
      end
   end

   always_comb begin
      ctl1l_d = hwdata[15:0] & `CCC_M_CTL1L;
      if (lock) begin
         ctl1l_d[`CCC_B_UEN] = uen;
         ctl1l_d[`CCC_B_LOCK] = (key_q == KEY_OPEN) ? hwdata[`CCC_B_LOCK] : 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctl1l_q <= 16'h0000;
      end else if (wr_ctl1l) begin
         ctl1l_q <= ctl1l_d;
      end
   end

   // Alarm hardware update wins over a colliding software write
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctl1h_q <= 16'h0000;
      end else begin
         if (wr_ctl1h) begin
            ctl1h_q <= hwdata[15:0] & `CCC_M_CTL1H;
         end
         if (alm_ev) begin
            if (rpt != 8'h00) begin
               ctl1h_q[7:0] <= rpt - 8'h01;
            end else if (ctl1h_q[`CCC_B_CHIME]) begin
               ctl1h_q[7:0] <= 8'hff;
            end else begin
               ctl1h_q[`CCC_B_ALEN] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctl2l_q <= 16'h0000;
         ctl2h_q <= `CCC_RST_CTL2H;
         ctl3l_q <= 16'h0000;
      end else begin
         if (wr_ctl2l) begin
            ctl2l_q <= hwdata[15:0] & `CCC_M_CTL2L;
         end
         if (wr_ctl2h) begin
            ctl2h_q <= hwdata[15:0];
         end
         if (wr_ctl3l) begin
            ctl3l_q <= hwdata[15:0];
         end
      end
   end

   // Two-flop synchronisers; the third stage feeds edge detection only
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= 4'hf;
         sync2_q <= 4'hf;
         sync3_q <= 4'hf;
      end else begin
         sync1_q <= {tamper_input_n, powerline_clock_pin, low_power_rc_osc, secondary_crystal_osc};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~sync3_q;
   assign fall = ~sync2_q & sync3_q;

   always_comb begin
      unique case (ctl2l_q[1:0])
         2'b00: src_p = rise[0];
         2'b01: src_p = rise[1];
         2'b10: src_p = rise[2];
         2'b11: src_p = 1'b1;
      endcase
   end

   assign pre_p = src_p & (ps_cnt_q >= pre_max(ctl2l_q[`CCC_L_PS +: 2]));
   assign pwc_p = src_p & (pwps_cnt_q >= pre_max(ctl2l_q[`CCC_L_POWER_CTRL_PRESCALE +: 2]));

   always_ff @(posedge mclk) begin
      if (rst) begin
         ps_cnt_q <= 8'h00;
         pwps_cnt_q <= 8'h00;
      end else begin
         if (src_p) begin
            ps_cnt_q <= pre_p ? 8'h00 : ps_cnt_q + 8'h01;
            pwps_cnt_q <= pwc_p ? 8'h00 : pwps_cnt_q + 8'h01;
         end
      end
   end

   assign half_tick = uen & pre_p & ~del_q & (div_cnt_q == 16'h0000);
   assign sec_tick = half_tick & half_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         div_cnt_q <= `CCC_RST_CTL2H;
         del_q <= 1'b0;
         hs_idx_q <= 5'h00;
      end else if (~uen) begin
         div_cnt_q <= ctl2h_q;
         del_q <= 1'b0;
      end else if (pre_p) begin
         if (del_q) begin
            del_q <= 1'b0;
         end else if (div_cnt_q == 16'h0000) begin
            div_cnt_q <= ctl2h_q;
            hs_idx_q <= hs_idx_q + 5'h01;
            // Deletes FRACTIONAL_DIVIDE pulses across 32 half seconds
            del_q <= hs_idx_q < ctl2l_q[`CCC_L_FRACTIONAL_DIVIDE +: 5];
         end else begin
            div_cnt_q <= div_cnt_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         half_q <= 1'b0;
      end else if (wr_sec) begin
         half_q <= 1'b0;
      end else if (half_tick) begin
         half_q <= ~half_q;
      end
   end

   assign alm_ev = half_tick & ctl1h_q[`CCC_B_ALEN]
      & alarm_hit(ctl1h_q[`CCC_L_ALARM_PERIOD_SELECT +: 4], field_match, sec_tick);
   assign ts_ev = ctl1l_q[`CCC_B_TSEN] & fall[3];

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_alm_q <= 1'b0;
         stat_ts_q <= 1'b0;
         ts_cap_q <= 1'b0;
      end else begin
         stat_alm_q <= alm_ev | (stat_alm_q & ~(wr_stat & ~hwdata[`CCC_B_ALMEV]));
         if (wr_stat) begin
            stat_ts_q <= ts_ev | hwdata[`CCC_B_TSEV];
         end else if (ts_ev) begin
            stat_ts_q <= 1'b1;
         end
         ts_cap_q <= ts_ev | (wr_stat & hwdata[`CCC_B_TSEV]);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pwc_q <= PWC_IDLE;
         pwc_cnt_q <= 8'h00;
      end else if (~ctl1l_q[`CCC_B_POWER_CTRL_ENABLE]) begin
         pwc_q <= PWC_IDLE;
      end else begin
         unique case (pwc_q)
            PWC_IDLE: begin
               if (alm_ev & (stab_len != 8'h00)) begin
                  pwc_q <= PWC_STAB;
                  pwc_cnt_q <= stab_len;
               end else if (alm_ev & (samp_len != 8'h00)) begin
                  pwc_q <= PWC_SAMP;
                  pwc_cnt_q <= samp_len;
               end
            end
            PWC_STAB: begin
               if (pwc_p & (pwc_cnt_q == 8'h01)) begin
                  pwc_q <= (samp_len != 8'h00) ? PWC_SAMP : PWC_IDLE;
                  pwc_cnt_q <= samp_len;
               end else if (pwc_p) begin
                  pwc_cnt_q <= pwc_cnt_q - 8'h01;
               end
            end
            PWC_SAMP: begin
               if (pwc_p & (pwc_cnt_q == 8'h01)) begin
                  pwc_q <= PWC_IDLE;
               end else if (pwc_p) begin
                  pwc_cnt_q <= pwc_cnt_q - 8'h01;
               end
            end
            default: pwc_q <= PWC_IDLE;
         endcase
      end
   end

   assign pwc_act = (pwc_q != PWC_IDLE) | (samp_len == `CCC_SAMP_ALWAYS);

   always_ff @(posedge mclk) begin
      if (rst) begin
         out_pin_q <= 1'b0;
         pwr_q <= 1'b0;
         pwr_en_q <= 1'b0;
         half_tick_q <= 1'b0;
      end else begin
         pwr_q <= ctl1l_q[`CCC_B_POWER_CTRL_POLARITY] ? pwc_act : ~pwc_act;
         pwr_en_q <= ctl1l_q[`CCC_B_POWER_CTRL_PIN_ENABLE];
         half_tick_q <= half_tick;
         if (~ctl1l_q[`CCC_B_OUTEN]) begin
            out_pin_q <= 1'b0;
         end else begin
            unique case (ctl1l_q[`CCC_L_OUTPUT_SELECT +: 3])
               3'h0: out_pin_q <= alm_ev;
               3'h1: out_pin_q <= ~half_q;
               3'h2: out_pin_q <= src_p;
               3'h3: out_pin_q <= pwc_act;
               3'h4: out_pin_q <= ts_ev;
               default: out_pin_q <= 1'b0;
            endcase
         end
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign output_pin = out_pin_q;
   assign power_ctrl_out = pwr_q;
   assign power_ctrl_pin_enable = pwr_en_q;
   assign timestamp_capture = ts_cap_q;
   assign half_tick_out = half_tick_q;

   a_ctl2_locked: assert property (@(posedge mclk) disable iff (rst)
      wr_data_ok & (a_q == `CCC_OFS_CTL2H) & lock |=> $stable(ctl2h_q))
      else $error("control two changed while locked");
   a_lock_plain_set: assert property (@(posedge mclk) disable iff (rst)
      wr_ctl1l & ~lock & hwdata[`CCC_B_LOCK] |=> lock)
      else $error("lock not set by plain write");
   a_lock_needs_key: assert property (@(posedge mclk) disable iff (rst)
      lock & (key_q != KEY_OPEN) |=> lock)
      else $error("lock cleared without key");
   a_ctl1h_open: assert property (@(posedge mclk) disable iff (rst)
      wr_ctl1h & lock & ~alm_ev |=> ctl1h_q == ($past(hwdata[15:0]) & `CCC_M_CTL1H))
      else $error("alarm control write lost under lock");
   a_no_count_off: assert property (@(posedge mclk) disable iff (rst)
      ~uen |=> (div_cnt_q == $past(ctl2h_q)) && !half_tick_q)
      else $error("divider ran while disabled");
   a_alarm_flag: assert property (@(posedge mclk) disable iff (rst)
      alm_ev |=> stat_alm_q)
      else $error("alarm flag not set");
   a_repeat_dec: assert property (@(posedge mclk) disable iff (rst)
      alm_ev & (rpt != 8'h00) |=> rpt == $past(rpt) - 8'h01)
      else $error("repeat count not decremented");
   a_repeat_stop: assert property (@(posedge mclk) disable iff (rst)
      alm_ev & (rpt == 8'h00) & ~ctl1h_q[`CCC_B_CHIME] |=> (rpt == 8'h00) && !ctl1h_q[`CCC_B_ALEN])
      else $error("alarm did not stop at zero");
   a_chime_wrap: assert property (@(posedge mclk) disable iff (rst)
      alm_ev & (rpt == 8'h00) & ctl1h_q[`CCC_B_CHIME] |=> rpt == 8'hff)
      else $error("chime did not wrap");
   a_half_clear: assert property (@(posedge mclk) disable iff (rst)
      wr_sec |=> ~half_q)
      else $error("half second not cleared");
   a_pin_off: assert property (@(posedge mclk) disable iff (rst)
      ~ctl1l_q[`CCC_B_OUTEN] |=> ~out_pin_q)
      else $error("output pin active while disabled");
endmodule : ccc_ctrl
`default_nettype wire

// ==== verification/ccc_ctrl_test.sv ====
/*
 Self-checking bench of the calendar clock control block: AHB-Lite tasks,
 then lock, timestamp, divider, alarm and power window sequences.
 Assumes hw/ccc_ctrl.sv, hw/ccc_pkg.sv and ccc_cfg.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ccc_cfg.svh"
module ccc_ctrl_test;
   import ccc_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic secondary_crystal_osc = 1'b0, low_power_rc_osc = 1'b0, powerline_clock_pin = 1'b0;
   logic tamper_input_n = 1'b1;
   logic [7:0] field_match = 8'hff;
   logic [31:0] hrdata;
   logic hready, hreadyout, hresp, output_pin, power_ctrl_out, power_ctrl_pin_enable;
   logic timestamp_capture, half_tick_out;
   // Registered outputs copied at the falling edge, so the bench never races the design
   logic rdy_n = 1'b1, tick_n = 1'b0, pin_n = 1'b0;
   logic [31:0] rd_n = 32'h0;
   int cap_cnt = 0, tick_cnt = 0, pwc_cnt = 0;
   int error_cnt = 0, n_checks = 0;
   assign hready = hreadyout;
   ccc_ctrl u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .secondary_crystal_osc(secondary_crystal_osc), .low_power_rc_osc(low_power_rc_osc),
      .powerline_clock_pin(powerline_clock_pin), .tamper_input_n(tamper_input_n), .field_match(field_match),
      .output_pin(output_pin), .power_ctrl_out(power_ctrl_out), .power_ctrl_pin_enable(power_ctrl_pin_enable),
      .timestamp_capture(timestamp_capture), .half_tick_out(half_tick_out));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // Reference clocks at whole multiples of mclk, fixed phase: tick spacing is exact
   initial begin
      #30;
      forever #400 secondary_crystal_osc = ~secondary_crystal_osc;
   end
   initial begin
      #30;
      forever #300 low_power_rc_osc = ~low_power_rc_osc;
   end
   initial begin
      #30;
      forever #500 powerline_clock_pin = ~powerline_clock_pin;
   end
   always @(negedge mclk) begin
      rdy_n <= hreadyout;
      rd_n <= hrdata;
      tick_n <= half_tick_out;
      pin_n <= output_pin;
      if (timestamp_capture === 1'b1) cap_cnt <= cap_cnt + 1;
      if (half_tick_out === 1'b1) tick_cnt <= tick_cnt + 1;
      if (power_ctrl_out === 1'b1) pwc_cnt <= pwc_cnt + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, output ccc_reg_t q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge mclk); while (rdy_n !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {16'h0, d};
      do @(posedge mclk); while (rdy_n !== 1'b1);
      q = rd_n[15:0];
      if (!wr) check({hresp, 15'h0, rd_n[31:16]}, 32'h0);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      ccc_reg_t q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output ccc_reg_t q);
      bus(1'b0, a, 16'h0, q);
   endtask : rd
   task automatic rd_chk(input logic [7:0] a, input ccc_reg_t e);
      ccc_reg_t q;
      bus(1'b0, a, 16'h0, q);
      check({16'h0, q}, {16'h0, e});
   endtask : rd_chk
   task automatic tick_wait;
      do @(posedge mclk); while (tick_n !== 1'b1);
   endtask : tick_wait
   // Cycles spanned by k whole half-second intervals
   task automatic span(input int k, output int n);
      tick_wait();
      n = 0;
      repeat (k) begin
         do begin
            @(posedge mclk);
            n++;
         end while (tick_n !== 1'b1);
      end
   endtask : span
   task automatic unlock_try(input logic [7:0] k1, input logic [7:0] k2, input logic extra);
      ccc_reg_t q;
      wr(`CCC_OFS_KEY, {8'h0, k1});
      wr(`CCC_OFS_KEY, {8'h0, k2});
      rd(`CCC_OFS_STATL, q);
      if (extra) wr(`CCC_OFS_CTL3L, 16'h0000);
      wr(`CCC_OFS_CTL1L, 16'h0000);
   endtask : unlock_try
   task automatic tamper_pulse;
      tamper_input_n <= 1'b0;
      repeat (4) @(posedge mclk);
      tamper_input_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask : tamper_pulse
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      #8_000_000;
      error_cnt++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      conclude();
   end
   initial begin
      ccc_reg_t q;
      int n, c0, per[4], dec[6], exp_pw[5];
      logic [3:0] am[6];
      logic [7:0] fmv[6];
      logic [1:0] pw[5];
      logic [15:0] win[5];
      logic hs;
      per = '{8, 6, 10, 1};
      am = '{4'h0, 4'h1, 4'h3, 4'h3, 4'ha, 4'hc};
      fmv = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hff};
      dec = '{2, 1, 1, 0, 0, 0};
      pw = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd0};
      win = '{16'h0201, 16'h0201, 16'h0200, 16'h0101, 16'h0001};
      exp_pw = '{3, 48, 128, 512, 1};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), (i == 3) ? `CCC_RST_CTL2H : 16'h0000);
      wr(`CCC_OFS_CTL2L, 16'hffff);
      rd_chk(`CCC_OFS_CTL2L, `CCC_M_CTL2L);
      wr(`CCC_OFS_CTL1H, 16'hffff);
      rd_chk(`CCC_OFS_CTL1H, `CCC_M_CTL1H);
      wr(8'h20, 16'hffff);
      rd_chk(8'h20, 16'h0000);
      wr(`CCC_OFS_CTL1L, 16'h77f1);
      rd_chk(`CCC_OFS_CTL1L, 16'h07f1);
      check({31'h0, power_ctrl_pin_enable}, 32'h1);
      wr(`CCC_OFS_CTL1L, 16'h0800);
      rd_chk(`CCC_OFS_CTL1L, 16'h0800);
      wr(`CCC_OFS_CTL2L, 16'h0013);
      rd_chk(`CCC_OFS_CTL2L, `CCC_M_CTL2L);
      wr(`CCC_OFS_CTL2H, 16'h0003);
      rd_chk(`CCC_OFS_CTL2H, `CCC_RST_CTL2H);
      wr(`CCC_OFS_CTL1L, 16'h8c00);
      rd_chk(`CCC_OFS_CTL1L, 16'h0c00);
      wr(`CCC_OFS_CTL3L, 16'h0201);
      rd_chk(`CCC_OFS_CTL3L, 16'h0201);
      wr(`CCC_OFS_CTL1H, 16'h0005);
      rd_chk(`CCC_OFS_CTL1H, 16'h0005);
      unlock_try(8'haa, 8'h55, 1'b0);
      rd_chk(`CCC_OFS_CTL1L, 16'h0800);
      unlock_try(8'h55, 8'haa, 1'b1);
      rd_chk(`CCC_OFS_CTL1L, 16'h0800);
      unlock_try(8'h55, 8'haa, 1'b0);
      rd_chk(`CCC_OFS_CTL1L, 16'h0000);
      wr(`CCC_OFS_CTL1L, 16'h0800);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(`CCC_OFS_CTL1L, 16'h0000);
      rd_chk(`CCC_OFS_CTL3L, 16'h0000);
      tamper_pulse();
      rd_chk(`CCC_OFS_STATL, 16'h0000);
      wr(`CCC_OFS_CTL1L, 16'h0001);
      c0 = cap_cnt;
      tamper_pulse();
      rd_chk(`CCC_OFS_STATL, 16'h0008);
      check(32'(cap_cnt - c0), 32'd1);
      wr(`CCC_OFS_STATL, 16'h0000);
      rd_chk(`CCC_OFS_STATL, 16'h0000);
      wr(`CCC_OFS_STATL, 16'h0008);
      rd_chk(`CCC_OFS_STATL, 16'h0008);
      check(32'(cap_cnt - c0), 32'd2);
      wr(`CCC_OFS_CTL2H, 16'h0003);
      wr(`CCC_OFS_CTL1L, 16'h8000);
      for (int s = 0; s < 4; s++) begin
         wr(`CCC_OFS_CTL2L, {14'h0, 2'(s)});
         span(1, n);
         check(32'(n), 32'(4 * per[s]));
      end
      wr(`CCC_OFS_CTL2L, {5'd5, 9'h0, 2'b11});
      span(32, n);
      check(32'(n), 32'd133);
      for (int p = 0; p < 4; p++) begin
         wr(`CCC_OFS_CTL2L, {10'h0, 2'(p), 4'b0011});
         span(1, n);
         check(32'(n), (p == 0) ? 32'd4 : 32'(16 << (2 * p)));
      end
      rd(`CCC_OFS_STATL, q);
      check({16'h0, q & 16'h0006}, 32'h6);
      tick_wait();
      rd(`CCC_OFS_STATL, q);
      hs = q[0];
      tick_wait();
      rd(`CCC_OFS_STATL, q);
      check({31'h0, q[0]}, {31'h0, ~hs});
      if (q[0] !== 1'b1) tick_wait();
      wr(`CCC_OFS_SECW, 16'h0000);
      rd(`CCC_OFS_STATL, q);
      check({31'h0, q[0]}, 32'h0);
      wr(`CCC_OFS_CTL1L, 16'h8090);
      repeat (2) begin
         tick_wait();
         rd(`CCC_OFS_STATL, q);
         check({31'h0, pin_n}, {31'h0, ~q[0]});
      end
      wr(`CCC_OFS_CTL1L, 16'h8010);
      rd(`CCC_OFS_STATL, q);
      check({31'h0, pin_n}, 32'h0);
      wr(`CCC_OFS_CTL1L, 16'h0000);
      c0 = tick_cnt;
      repeat (2100) @(posedge mclk);
      check(32'(tick_cnt - c0), 32'h0);
      rd_chk(`CCC_OFS_STATL, 16'h0008);
      wr(`CCC_OFS_CTL1L, 16'h8000);
      for (int i = 0; i < 6; i++) begin
         field_match <= fmv[i];
         tick_wait();
         wr(`CCC_OFS_CTL1H, {4'h8, am[i], 8'd10});
         repeat (2) tick_wait();
         rd_chk(`CCC_OFS_CTL1H, {4'h8, am[i], 8'(10 - dec[i])});
      end
      tick_wait();
      wr(`CCC_OFS_CTL1H, 16'h8001);
      tick_wait();
      rd_chk(`CCC_OFS_CTL1H, 16'h8000);
      tick_wait();
      rd_chk(`CCC_OFS_CTL1H, 16'h0000);
      rd(`CCC_OFS_STATL, q);
      check({16'h0, q & 16'h0020}, 32'h20);
      wr(`CCC_OFS_STATL, 16'h0000);
      rd(`CCC_OFS_STATL, q);
      check({16'h0, q & 16'h0020}, 32'h0);
      wr(`CCC_OFS_CTL1H, 16'hc000);
      tick_wait();
      rd_chk(`CCC_OFS_CTL1H, 16'hc0ff);
      // Chime keeps the alarm firing each half second to trigger the power window
      wr(`CCC_OFS_CTL1L, 16'h8700);
      for (int i = 0; i < 5; i++) begin
         // Both prescalers at 1:1 first, so they restart in step and windows span whole periods
         wr(`CCC_OFS_CTL2L, 16'h0003);
         wr(`CCC_OFS_CTL2L, {8'h0, pw[i], 6'b110011});
         wr(`CCC_OFS_CTL3L, win[i]);
         repeat (2) tick_wait();
         c0 = pwc_cnt;
         tick_wait();
         check(32'(pwc_cnt - c0), 32'(exp_pw[i]));
      end
      wr(`CCC_OFS_CTL1L, 16'h83b0);
      wr(`CCC_OFS_CTL3L, 16'hff00);
      tick_wait();
      c0 = pwc_cnt;
      tick_wait();
      check(32'(pwc_cnt - c0), 32'd1024);
      check({31'h0, pin_n}, 32'h1);
      conclude();
   end
endmodule : ccc_ctrl_test
`default_nettype wire
